// ---- hdl/isp_access_and_protection.sv ----
// Purpose: decides which programming path may modify which block
// Assumes: port c and strap async, rest on ref_clk
// Notes:   accepted ops leave as one-cycle grants
//
// Design decisions made here: the APB slave port and the register offsets.

// Behaviour
// R1 - serial mode maps port c pins to test signals
// R2 - status and error pins are optional extras
// R3 - serial port programs whole device without host
// R4 - host programs memory it does not run from; code allows secondary only when host_fetch is FETCH_PRIMARY
// R5 - per-path table of programmable blocks
// R6 - security lock never writable by host
// R7 - only full-chip erase clears security lock
// R8 - per-sector protection for both memories
// R9 - shipped state: config zero, erased data ones
// R10 - serial disabled: pins keep function, traffic ignored
module isp_access_and_protection (
    input  wire logic                  ref_clk,
    input  wire logic                  resetn,
    input  wire logic                  ce,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  serial_pin_en,
    input  wire logic [7:0]            portc_in,
    input  wire logic [7:0]            func_out,
    input  wire logic [7:0]            func_oe_n,
    output logic      [7:0]            portc_out,
    output logic      [7:0]            portc_oe_n,
    input  wire isp_access_pkg::fetch_t host_fetch,
    input  wire logic                  ipg_valid,
    input  wire isp_access_pkg::cmd_t  ipg_cmd,
    output logic                       ipg_ready,
    output logic                       ipg_refused,
    output isp_access_pkg::grant_t     nvm_grant,
    output logic                       security_lock,
    output logic      [7:0]            cfg_out
);
    localparam int FRAME_W = $bits(isp_access_pkg::cmd_t);
    localparam int PW      = isp_access_pkg::PROT_W;

    // two-flop synchronisers: port c and strap
    logic [8:0] sync1_q, sync2_q;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1_q <= 9'h000;
            sync2_q <= 9'h000;
        end
        else if (ce)
        begin
            sync1_q <= {serial_pin_en, portc_in};
            sync2_q <= sync1_q;
        end
    end

    logic ctrl_ser_en_q, ctrl_ser_en_d;
    logic ser_on;
    // strap alone opens the port, no host step needed
    assign ser_on = ctrl_ser_en_q | sync2_q[8]; // R3

    logic                       frame_valid, tdo;
    isp_access_pkg::cmd_t       frame;
    logic [FRAME_W-1:0]         resp;
    logic                       lock_q, lock_d;
    logic [PW-1:0]              prot_q, prot_d;
    logic [7:0]                 cfg_q, cfg_d;
    logic                       ser_ref_q, ser_ref_d;

    // lock hides cfg and prot from serial read-back
    assign resp = lock_q ? {8'h00, 1'b1, ser_ref_q, 14'h0000}
                         : {cfg_q, 1'b0, ser_ref_q, 2'b00, prot_q};

    serial_frame_shifter #(
        .FRAME_W (FRAME_W)
    ) u_shift (
        .ref_clk     (ref_clk),
        .resetn      (resetn),
        .ce          (ce),
        .enable      (ser_on),
        .mode_sel    (sync2_q[isp_access_pkg::PIN_MODE]), // R1
        .test_clk    (sync2_q[isp_access_pkg::PIN_CLK]),
        .data_in     (sync2_q[isp_access_pkg::PIN_DIN]),
        .resp        (resp),
        .frame_valid (frame_valid),
        .frame       (frame),
        .data_out    (tdo)
    );

    // pending requests from the three paths
    logic                 ser_pend_q, ser_pend_d, ipg_pend_q, ipg_pend_d;
    logic                 host_pend_q, host_pend_d;
    isp_access_pkg::cmd_t ser_cmd_q, ser_cmd_d, ipg_cmd_q, ipg_cmd_d;
    isp_access_pkg::cmd_t host_cmd_q, host_cmd_d;
    logic                 ipg_ready_q, ipg_ref_q, ipg_ref_d, host_ref_q, host_ref_d;
    isp_access_pkg::grant_t grant_q, grant_d;

    // apb state
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d, pslverr_q, pslverr_d;
    logic        setup, access, hcmd_wr;
    assign setup  = psel & ~penable;
    assign access = psel & penable & pready_q & ~pslverr_q;
    assign hcmd_wr = access & pwrite & (paddr == isp_access_pkg::OFS_HOST_CMD);

    // apb decode; zero wait states
    always_comb
    begin
        prdata_d  = prdata_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        if (setup)
        begin
            pready_d = 1'b1;
            prdata_d = 32'h0000_0000;
            if (paddr == isp_access_pkg::OFS_CTRL)
                prdata_d[isp_access_pkg::CTRL_SER_EN] = ctrl_ser_en_q;
            else if (paddr == isp_access_pkg::OFS_PROT)
                prdata_d[PW-1:0] = prot_q; // R8
            else if (paddr == isp_access_pkg::OFS_HOST_CMD)
            begin
                prdata_d[FRAME_W-1:0] = host_cmd_q;
                pslverr_d = pwrite & host_pend_q; // busy: command dropped
            end
            else if (paddr == isp_access_pkg::OFS_STATUS)
            begin
                prdata_d[isp_access_pkg::ST_LOCK]      = lock_q;
                prdata_d[isp_access_pkg::ST_HOST_BUSY] = host_pend_q;
                prdata_d[isp_access_pkg::ST_HOST_REF]  = host_ref_q;
                prdata_d[isp_access_pkg::ST_SER_ON]    = ser_on;
                prdata_d[isp_access_pkg::ST_SER_REF]   = ser_ref_q;
                prdata_d[isp_access_pkg::ST_CFG_LSB +: 8] = cfg_q;
            end
            else
                pslverr_d = 1'b1; // unmapped address
        end
    end

    // arbitration and access decision
    isp_access_pkg::source_t src;
    isp_access_pkg::cmd_t    cmd;
    logic issue, refuse, mem, sec_ok, prot_hit, host, ser;
    always_comb
    begin
        issue = ser_pend_q | ipg_pend_q | host_pend_q;
        src   = isp_access_pkg::SRC_HOST;
        cmd   = host_cmd_q;
        if (ser_pend_q)
        begin
            src = isp_access_pkg::SRC_SERIAL;
            cmd = ser_cmd_q;
        end
        else if (ipg_pend_q)
        begin
            src = isp_access_pkg::SRC_PROGRAMMER;
            cmd = ipg_cmd_q;
        end
        host = (src == isp_access_pkg::SRC_HOST);
        ser  = (src == isp_access_pkg::SRC_SERIAL);
        mem  = (cmd.target == isp_access_pkg::TGT_PRIMARY) ||
               (cmd.target == isp_access_pkg::TGT_SECONDARY);
        sec_ok   = 1'b1;
        prot_hit = 1'b0;
        if (cmd.target == isp_access_pkg::TGT_PRIMARY)
        begin
            sec_ok   = cmd.sector < 8'(isp_access_pkg::PRIMARY_SECTORS);
            prot_hit = prot_q[cmd.sector[2:0]];
        end
        else if (cmd.target == isp_access_pkg::TGT_SECONDARY)
        begin
            sec_ok   = cmd.sector < 8'(isp_access_pkg::SECONDARY_SECTORS);
            prot_hit = prot_q[isp_access_pkg::PROT_SEC_LSB + 32'(cmd.sector[1:0])];
        end
        refuse = 1'b0;
        case (cmd.op)
            isp_access_pkg::OP_PROG, isp_access_pkg::OP_ERASE:
            begin
                if (cmd.target > isp_access_pkg::TGT_OTP)
                    refuse = 1'b1;
                if (host && !mem && cmd.target != isp_access_pkg::TGT_OTP)
                    refuse = 1'b1; // R5
                if (ser && cmd.target == isp_access_pkg::TGT_OTP)
                    refuse = 1'b1; // R5
                if (cmd.op == isp_access_pkg::OP_ERASE &&
                    cmd.target == isp_access_pkg::TGT_OTP)
                    refuse = 1'b1;
                if (host && cmd.target == isp_access_pkg::TGT_PRIMARY &&
                    host_fetch == isp_access_pkg::FETCH_PRIMARY)
                    refuse = 1'b1; // R4
                if (host && cmd.target == isp_access_pkg::TGT_SECONDARY &&
                    host_fetch != isp_access_pkg::FETCH_PRIMARY)
                    refuse = 1'b1; // R4
                if (mem && (!sec_ok || prot_hit))
                    refuse = 1'b1; // R8
                if (!host && lock_q)
                    refuse = 1'b1; // locked part takes no prog or erase from serial or programmer
            end
            isp_access_pkg::OP_CHIP_ERASE: refuse = host; // R3
            isp_access_pkg::OP_SET_LOCK:   refuse = host; // R6
            isp_access_pkg::OP_WR_PROT:    refuse = !mem || (!host && lock_q); // R8
            isp_access_pkg::OP_WR_CFG:     refuse = host || lock_q; // R5
            default:                       refuse = 1'b1;
        endcase
    end

    // protected state, request queues and grant
    always_comb
    begin
        lock_d        = lock_q;
        prot_d        = prot_q;
        cfg_d         = cfg_q;
        ctrl_ser_en_d = ctrl_ser_en_q;
        ser_ref_d     = ser_ref_q;
        ipg_ref_d     = 1'b0;
        host_ref_d    = host_ref_q;
        ser_cmd_d     = frame_valid ? frame : ser_cmd_q;
        ipg_cmd_d     = (ipg_valid && ipg_ready_q) ? ipg_cmd : ipg_cmd_q;
        host_cmd_d    = hcmd_wr ? isp_access_pkg::cmd_t'(pwdata[FRAME_W-1:0]) : host_cmd_q;
        // set wins over clear
        ser_pend_d  = (ser_pend_q & ~(issue & ser)) | frame_valid;
        ipg_pend_d  = (ipg_pend_q & ~(issue & src == isp_access_pkg::SRC_PROGRAMMER)) |
                      (ipg_valid & ipg_ready_q);
        host_pend_d = (host_pend_q & ~(issue & host)) | hcmd_wr;
        if (access && pwrite && paddr == isp_access_pkg::OFS_CTRL)
            ctrl_ser_en_d = pwdata[isp_access_pkg::CTRL_SER_EN];
        if (access && pwrite && paddr == isp_access_pkg::OFS_PROT)
            prot_d = pwdata[PW-1:0]; // R8
        grant_d       = '0;
        grant_d.src   = src;
        grant_d.cmd   = cmd;
        if (issue)
        begin
            if (ser)
                ser_ref_d = refuse;
            else if (host)
                host_ref_d = refuse;
            else
                ipg_ref_d = refuse;
            grant_d.valid = ~refuse;
            if (!refuse)
            begin
                case (cmd.op)
                    isp_access_pkg::OP_SET_LOCK: lock_d = 1'b1; // R6
                    isp_access_pkg::OP_CHIP_ERASE:
                    begin
                        lock_d = isp_access_pkg::LOCK_RESET; // R7
                        prot_d = isp_access_pkg::PROT_RESET;
                        cfg_d  = isp_access_pkg::CFG_RESET; // R9
                        grant_d.cmd.data = isp_access_pkg::ERASED_BYTE; // R9
                    end
                    isp_access_pkg::OP_ERASE:
                        grant_d.cmd.data = isp_access_pkg::ERASED_BYTE; // R9
                    isp_access_pkg::OP_WR_PROT:
                        if (cmd.target == isp_access_pkg::TGT_PRIMARY)
                            prot_d[isp_access_pkg::PROT_SEC_LSB-1:0] = cmd.data; // R8
                        else
                            prot_d[PW-1:isp_access_pkg::PROT_SEC_LSB] = cmd.data[3:0];
                    isp_access_pkg::OP_WR_CFG: cfg_d = cmd.data;
                    default: ;
                endcase
            end
        end
    end

    // port c serial overrides
    logic [7:0] ser_in_mask, ser_val, pin_out_d, pin_oe_n_d;
    logic [7:0] pin_out_q, pin_oe_n_q;
    always_comb
    begin
        ser_in_mask = 8'h00;
        ser_val     = 8'h00;
        ser_in_mask[isp_access_pkg::PIN_MODE] = 1'b1; // R1
        ser_in_mask[isp_access_pkg::PIN_CLK]  = 1'b1;
        ser_in_mask[isp_access_pkg::PIN_DIN]  = 1'b1;
        ser_val[isp_access_pkg::PIN_STAT] = ser_pend_q; // R2
        ser_val[isp_access_pkg::PIN_ERR]  = ser_ref_q; // R2
        ser_val[isp_access_pkg::PIN_DOUT] = tdo;
    end

    for (genvar i = 0; i < 8; i++)
    begin : g_pin
        localparam bit IS_SER = (i == isp_access_pkg::PIN_MODE) ||
                                (i == isp_access_pkg::PIN_CLK)  ||
                                (i == isp_access_pkg::PIN_STAT) ||
                                (i == isp_access_pkg::PIN_ERR)  ||
                                (i == isp_access_pkg::PIN_DIN)  ||
                                (i == isp_access_pkg::PIN_DOUT);
        // others keep own function
        assign pin_out_d[i]  = (ser_on && IS_SER) ? ser_val[i] : func_out[i]; // R10
        assign pin_oe_n_d[i] = (ser_on && IS_SER) ? ser_in_mask[i] : func_oe_n[i]; // R1
    end

    // all registers except the synchronisers; reset is shipped state
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            lock_q        <= isp_access_pkg::LOCK_RESET;
            prot_q        <= isp_access_pkg::PROT_RESET;
            cfg_q         <= isp_access_pkg::CFG_RESET; // R9
            ctrl_ser_en_q <= 1'b0;
            ser_ref_q     <= 1'b0;
            ipg_ref_q     <= 1'b0;
            host_ref_q    <= 1'b0;
            ser_pend_q    <= 1'b0;
            ipg_pend_q    <= 1'b0;
            host_pend_q   <= 1'b0;
            ser_cmd_q     <= '0;
            ipg_cmd_q     <= '0;
            host_cmd_q    <= '0;
            ipg_ready_q   <= 1'b1;
            grant_q       <= '0;
            prdata_q      <= 32'h0000_0000;
            pready_q      <= 1'b0;
            pslverr_q     <= 1'b0;
            pin_out_q     <= 8'h00;
            pin_oe_n_q    <= 8'hff;
        end
        else if (ce)
        begin
            lock_q        <= lock_d;
            prot_q        <= prot_d;
            cfg_q         <= cfg_d;
            ctrl_ser_en_q <= ctrl_ser_en_d;
            ser_ref_q     <= ser_ref_d;
            ipg_ref_q     <= ipg_ref_d;
            host_ref_q    <= host_ref_d;
            ser_pend_q    <= ser_pend_d;
            ipg_pend_q    <= ipg_pend_d;
            host_pend_q   <= host_pend_d;
            ser_cmd_q     <= ser_cmd_d;
            ipg_cmd_q     <= ipg_cmd_d;
            host_cmd_q    <= host_cmd_d;
            ipg_ready_q   <= ~ipg_pend_d;
            grant_q       <= grant_d;
            prdata_q      <= prdata_d;
            pready_q      <= pready_d;
            pslverr_q     <= pslverr_d;
            pin_out_q     <= pin_out_d;
            pin_oe_n_q    <= pin_oe_n_d;
        end
    end

    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign portc_out     = pin_out_q;
    assign portc_oe_n    = pin_oe_n_q;
    assign ipg_ready     = ipg_ready_q;
    assign ipg_refused   = ipg_ref_q;
    assign nvm_grant     = grant_q;
    assign security_lock = lock_q;
    assign cfg_out       = cfg_q;
endmodule

// ---- hdl/isp_access_pkg.sv ----
// Purpose: shared constants and types for the programming access block
// Assumes: 32-bit apb, one word per register
// Notes:   serial frame and host command share the cmd_t layout
package isp_access_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_PROT     = 8'h04;
    localparam logic [7:0] OFS_HOST_CMD = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0c;

    // field positions
    localparam int CTRL_SER_EN  = 0;
    localparam int PROT_SEC_LSB = 8;
    localparam int ST_LOCK      = 0;
    localparam int ST_HOST_BUSY = 1;
    localparam int ST_HOST_REF  = 2;
    localparam int ST_SER_ON    = 3;
    localparam int ST_SER_REF   = 4;
    localparam int ST_CFG_LSB   = 8;

    // port c pin positions in serial mode
    localparam int PIN_MODE = 0;
    localparam int PIN_CLK  = 1;
    localparam int PIN_STAT = 3;
    localparam int PIN_ERR  = 4;
    localparam int PIN_DIN  = 5;
    localparam int PIN_DOUT = 6;

    // array sizes and shipped values
    localparam int         PRIMARY_SECTORS   = 8;
    localparam int         SECONDARY_SECTORS = 4;
    localparam int         PROT_W            = PRIMARY_SECTORS + SECONDARY_SECTORS;
    localparam logic [7:0] ERASED_BYTE       = 8'hff;
    localparam logic [7:0] CFG_RESET         = 8'h00;
    localparam logic [11:0] PROT_RESET       = 12'h000;
    localparam logic       LOCK_RESET        = 1'b0;

    typedef enum logic [3:0] {
        OP_NONE, OP_PROG, OP_ERASE, OP_CHIP_ERASE, OP_SET_LOCK, OP_WR_PROT, OP_WR_CFG
    } op_t;

    typedef enum logic [3:0] {
        TGT_PRIMARY, TGT_SECONDARY, TGT_DECODE_LA, TGT_GENERAL_LA, TGT_CONFIG, TGT_OTP
    } target_t;

    typedef enum logic [1:0] {SRC_SERIAL, SRC_PROGRAMMER, SRC_HOST} source_t;

    typedef enum logic [1:0] {FETCH_PRIMARY, FETCH_SECONDARY, FETCH_SRAM, FETCH_OTHER} fetch_t;

    typedef struct packed {
        op_t        op;
        target_t    target;
        logic [7:0] sector;
        logic [7:0] data;
    } cmd_t;

    typedef struct packed {
        logic    valid;
        source_t src;
        cmd_t    cmd;
    } grant_t;

endpackage

// ---- hdl/serial_frame_shifter.sv ----
// Purpose: serial test-port frame shifter, sampled on ref_clk
// Assumes: inputs already synchronised
// Notes:   a frame counts only if exactly FRAME_W bits were shifted
module serial_frame_shifter #(
    parameter int FRAME_W = 24
) (
    input  wire logic               ref_clk,
    input  wire logic               resetn,
    input  wire logic               ce,
    input  wire logic               enable,
    input  wire logic               mode_sel,
    input  wire logic               test_clk,
    input  wire logic               data_in,
    input  wire logic [FRAME_W-1:0] resp,
    output logic                    frame_valid,
    output logic [FRAME_W-1:0]      frame,
    output logic                    data_out
);
    localparam int CW = $clog2(FRAME_W + 1);

    if (FRAME_W < 2) $error("FRAME_W must be at least 2");

    logic               clk_prev_q, clk_prev_d, mode_prev_q, mode_prev_d;
    logic [CW-1:0]      cnt_q, cnt_d;
    logic [FRAME_W-1:0] in_q, in_d, out_q, out_d;
    logic               valid_q, valid_d;

    // edge detect and shift
    always_comb
    begin
        clk_prev_d  = test_clk;
        mode_prev_d = mode_sel;
        cnt_d       = cnt_q;
        in_d        = in_q;
        out_d       = out_q;
        valid_d     = 1'b0;
        if (!enable)
        begin
            cnt_d = '0; // R10
        end
        else if (mode_sel && !mode_prev_q)
        begin
            cnt_d = '0;
            out_d = resp;
        end
        else if (mode_sel && test_clk && !clk_prev_q)
        begin
            in_d  = {in_q[FRAME_W-2:0], data_in};
            out_d = {out_q[FRAME_W-2:0], 1'b0};
            if (cnt_q != CW'(FRAME_W + 1))
                cnt_d = cnt_q + CW'(1); // saturates one past a full frame
        end
        else if (!mode_sel && mode_prev_q)
        begin
            valid_d = (cnt_q == CW'(FRAME_W));
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            clk_prev_q  <= 1'b0;
            mode_prev_q <= 1'b0;
            cnt_q       <= '0;
            in_q        <= '0;
            out_q       <= '0;
            valid_q     <= 1'b0;
        end
        else if (ce)
        begin
            clk_prev_q  <= clk_prev_d;
            mode_prev_q <= mode_prev_d;
            cnt_q       <= cnt_d;
            in_q        <= in_d;
            out_q       <= out_d;
            valid_q     <= valid_d;
        end
    end

    assign frame_valid = valid_q;
    assign frame       = in_q;
    assign data_out    = out_q[FRAME_W-1];
endmodule

// ---- verif/isp_access_properties.sv ----
// Purpose: port checks for the access block
// Assumes: one clock domain, async active-low reset
// Notes:   grant checks use the grant pulse
module isp_access_properties (
    input wire logic                   ref_clk,
    input wire logic                   resetn,
    input wire logic [7:0]             func_out,
    input wire logic [7:0]             func_oe_n,
    input wire logic [7:0]             portc_out,
    input wire logic [7:0]             portc_oe_n,
    input wire isp_access_pkg::fetch_t host_fetch,
    input wire isp_access_pkg::grant_t nvm_grant,
    input wire logic                   security_lock,
    input wire logic [7:0]             cfg_out
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // grant classes by source and op
    wire       host_g = nvm_grant.valid && nvm_grant.src == isp_access_pkg::SRC_HOST;
    wire       host_pe = host_g && nvm_grant.cmd.op < isp_access_pkg::OP_CHIP_ERASE;
    wire       ser_g = nvm_grant.valid && nvm_grant.src == isp_access_pkg::SRC_SERIAL;
    wire       chip_g = nvm_grant.valid && nvm_grant.cmd.op == isp_access_pkg::OP_CHIP_ERASE;
    wire       era_g = nvm_grant.valid && nvm_grant.cmd.op == isp_access_pkg::OP_ERASE;
    wire [3:0] tgt = nvm_grant.cmd.target;
    // two samples in normal pin mode
    sequence normal_run;
        resetn && func_oe_n[6] && portc_oe_n[6] ##1 func_oe_n[6] && portc_oe_n[6];
    endsequence
    // lock falls from set to clear
    sequence lock_drop;
        security_lock ##1 !security_lock;
    endsequence
    pin_map_a: assert property (func_oe_n[6] && !portc_oe_n[6] |->
        portc_oe_n[1:0] == 2'h3 && portc_oe_n[5] && portc_oe_n[4:3] == 2'h0)
        else $error("serial pin enables wrong");
    pins_keep_a: assert property (normal_run |->
        portc_out == $past(func_out) && portc_oe_n == $past(func_oe_n))
        else $error("port c left its function");
    host_lock_a: assert property (host_g |->
        nvm_grant.cmd.op != isp_access_pkg::OP_SET_LOCK) else $error("host set lock");
    lock_clear_a: assert property (lock_drop |->
        chip_g || $past(chip_g) || $past(chip_g, 2)) else $error("lock cleared w/o erase");
    serial_otp_a: assert property (ser_g |->
        tgt != isp_access_pkg::TGT_OTP) else $error("serial reached otp");
    host_target_a: assert property (host_g |-> tgt < isp_access_pkg::TGT_DECODE_LA
        || tgt == isp_access_pkg::TGT_OTP) else $error("host reached logic or config");
    host_prim_a: assert property (host_pe && tgt == isp_access_pkg::TGT_PRIMARY |->
        host_fetch != isp_access_pkg::FETCH_PRIMARY) else $error("host wrote own primary");
    host_sec_a: assert property (host_pe && tgt == isp_access_pkg::TGT_SECONDARY |->
        host_fetch == isp_access_pkg::FETCH_PRIMARY) else $error("host wrote secondary");
    shipped_state_a: assert property ($rose(resetn) |->
        cfg_out == isp_access_pkg::CFG_RESET && !security_lock) else $error("bad reset state");
    erase_ones_a: assert property (chip_g || era_g |->
        nvm_grant.cmd.data == isp_access_pkg::ERASED_BYTE) else $error("erase data not ones");
endmodule

bind isp_access_and_protection isp_access_properties props (.*);

// ---- verif/prog_model.sv ----
// Purpose: serial programmer model on port c
// Assumes: 125 ns test clock, 24-bit frames, msb first
// Notes:   status and error pins unused
module prog_model (
    output logic [7:0] pins
);
    timeunit 1ns;
    timeprecision 100ps;
    initial pins = 8'h00;
    // one frame; clock idle outside it
    task automatic send(input logic [23:0] f);
        pins[0] = 1'b1;
        for (int i = 23; i >= 0; i--)
        begin
            pins[5] = f[i];
            #62.5 pins[1] = 1'b1;
            #62.5 pins[1] = 1'b0;
        end
        #62.5 pins[0] = 1'b0;
        pins[5] = ~pins[5]; // released line must not look held
        #125;
    endtask
endmodule

// ---- verif/tb.sv ----
// Purpose: self-checking bench for the programming access block
// Assumes: serial frames from prog_model
// Notes:   ce held high
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct packed {logic [1:0] f; logic [23:0] c; logic rf;} row_t;
    logic                   ref_clk = 1'b0, resetn = 1'b0, serial_pin_en = 1'b0, ipg_valid = 1'b0;
    logic                   psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]             paddr = 8'h00, func_out = 8'h00, func_oe_n = 8'hff;
    logic [31:0]            pwdata = 32'h0, prdata, r;
    logic                   pready, pslverr, security_lock, e, rf;
    logic [7:0]             pins, portc_out, portc_oe_n, cfg_out;
    logic [23:0]            exp;
    isp_access_pkg::fetch_t host_fetch = isp_access_pkg::FETCH_OTHER;
    isp_access_pkg::grant_t nvm_grant, last_g;
    int                     err_count = 0, checks_done = 0, gcnt = 0, cyc = 0, g0;
    // host commands: fetch place, command word, refusal expected
    row_t rows[15] = '{'{2'h1,24'h100000,1'b0}, '{2'h0,24'h100100,1'b1},
        '{2'h0,24'h110300,1'b0}, '{2'h2,24'h110000,1'b1}, '{2'h2,24'h100700,1'b0},
        '{2'h2,24'h100800,1'b1}, '{2'h2,24'h120000,1'b1}, '{2'h2,24'h130000,1'b1},
        '{2'h2,24'h140000,1'b1}, '{2'h2,24'h150000,1'b0}, '{2'h2,24'h400000,1'b1},
        '{2'h2,24'h300000,1'b1}, '{2'h2,24'h600000,1'b1}, '{2'h2,24'h200200,1'b0},
        '{2'h0,24'h510000,1'b0}};
    prog_model pm (.pins(pins));
    isp_access_and_protection DUT (.ref_clk, .resetn, .ce(1'b1), .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .serial_pin_en, .portc_in(pins),
        .func_out, .func_oe_n, .portc_out, .portc_oe_n, .host_fetch, .ipg_valid,
        .ipg_cmd(exp), .ipg_ready(), .ipg_refused(), .nvm_grant, .security_lock, .cfg_out);
    always #5 ref_clk = ~ref_clk;
    // grant log; one-cycle pulses count once
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (nvm_grant.valid === 1'b1)
        begin
            last_g <= nvm_grant;
            gcnt <= gcnt + 1;
        end
        if (cyc == 20000)
        begin
            err_count++;
            summarize();
        end
    end
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        checks_done++;
        if (s !== x)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask
    // one transfer, then an idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    // host command, poll until done
    task automatic hcmd(input logic [1:0] f, input logic [23:0] c);
        host_fetch <= isp_access_pkg::fetch_t'(f);
        apb(1'b1, isp_access_pkg::OFS_HOST_CMD, {8'h00, c});
        do apb(1'b0, isp_access_pkg::OFS_STATUS, 32'h0); while (r[1] !== 1'b0);
        rf = r[2];
    endtask
    task automatic ser(input logic [23:0] f);
        pm.send(f);
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        foreach (rows[i])
        begin
            g0 = gcnt;
            hcmd(rows[i].f, rows[i].c);
            chk("host refused", rf, rows[i].rf);
            chk("grant count", gcnt - g0, !rows[i].rf);
            exp = rows[i].c;
            if (exp[23:20] == 4'h2)
                exp[7:0] = 8'hff;
            if (!rows[i].rf)
                chk("grant", {last_g.src, last_g.cmd}, {isp_access_pkg::SRC_HOST, exp});
        end
        $display("test host table done");
        chk("shipped", {security_lock, cfg_out}, 9'h000);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", {e, r[30:0]}, 32'h8000_0000);
        apb(1'b1, isp_access_pkg::OFS_PROT, 32'h1);
        hcmd(2'h1, 24'h100000);
        chk("protected", rf, 1'b1);
        apb(1'b0, isp_access_pkg::OFS_PROT, 32'h0);
        chk("prot back", r, 32'h1);
        $display("test protection done");
        func_out <= 8'h5a;
        func_oe_n <= 8'h4f;
        ser(24'h400000);
        chk("pins normal", {portc_oe_n, portc_out, security_lock}, 17'h09eb4);
        serial_pin_en <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk("pins serial", portc_oe_n, 8'h27);
        ser(24'h400000);
        chk("lock set", security_lock, 1'b1);
        hcmd(2'h1, 24'h300000);
        chk("host erase", {rf, security_lock}, 2'h3);
        ser(24'h150000);
        chk("otp refused", portc_out[4], 1'b1);
        ser(24'h300000);
        chk("erased", {security_lock, last_g.cmd.data, cfg_out}, 17'h0ff00);
        ser(24'h130000);
        chk("serial array", {last_g.src, last_g.cmd.target, portc_out[4]}, 7'h06);
        exp <= 24'h150000;
        ipg_valid <= 1'b1;
        @(posedge ref_clk);
        ipg_valid <= 1'b0;
        repeat (4) @(posedge ref_clk);
        chk("prog otp", {last_g.src, last_g.cmd}, {isp_access_pkg::SRC_PROGRAMMER, exp});
        $display("test serial done");
        summarize();
    end
endmodule
